// [verilog/pdw_defines.vh]
// Constants for the power-down wake-up sequencer.
`ifndef PDW_DEFINES_VH
`define PDW_DEFINES_VH
`define PDW_CLK_MHZ        50
`define PDW_LATCH_US       10
`define PDW_LATCH_CYC      (`PDW_LATCH_US * `PDW_CLK_MHZ)
`define PDW_STARTUP_MS     5
`define PDW_STARTUP_CYC    (`PDW_STARTUP_MS * 1000 * `PDW_CLK_MHZ)
`define PDW_SUSPEND_MS     6
`define PDW_SUSPEND_CYC    (`PDW_SUSPEND_MS * 1000 * `PDW_CLK_MHZ)
`define PDW_CNT_W          24
`define PDW_WAKE_VECTOR    16'h007b
`define PDW_CFG_PIN        8'h80
`define PDW_CFG_USB        8'h90
`define PDW_CFG_EN_BIT     7
`define PDW_CFG_SRC_BIT    4
`endif

// [verilog/pdw_usb_suspend.v]
// USB suspend detector that raises a wake trigger on resumed bus activity.
`timescale 1ns/1ns
`default_nettype none
`include "pdw_defines.vh"
module pdw_usb_suspend #(
  parameter SUSPEND_CYC = `PDW_SUSPEND_CYC
) (
  input  wire clk,
  input  wire rst_b,
  input  wire usb_activity,
  input  wire usb_rx_enable,
  output reg  usb_suspended,
  output reg  usb_wake_trig
);
  reg [`PDW_CNT_W-1:0] idle_cnt_reg;

  // Idle time is counted while the bus is quiet or the receiver is off; suspend follows after the limit.
  always @(posedge clk) begin
    if (!rst_b) begin
      idle_cnt_reg  <= {`PDW_CNT_W{1'b0}};
      usb_suspended <= 1'b0;
      usb_wake_trig <= 1'b0;
    end else begin
      usb_wake_trig <= 1'b0;
      if (usb_activity && usb_rx_enable) begin
        idle_cnt_reg <= {`PDW_CNT_W{1'b0}};
        if (usb_suspended) begin
          usb_suspended <= 1'b0;
          usb_wake_trig <= 1'b1;
        end
      end else if (!usb_suspended) begin
        if (idle_cnt_reg >= SUSPEND_CYC[`PDW_CNT_W-1:0]) begin
          usb_suspended <= 1'b1;
        end else begin
          idle_cnt_reg <= idle_cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/pdw_sequencer.v]
// Power-down wake-up sequencer: wake source selection, start-up delay and resume control.
`timescale 1ns/1ns
`default_nettype none
`include "pdw_defines.vh"
module pdw_sequencer #(
  parameter LATCH_CYC   = `PDW_LATCH_CYC,
  parameter STARTUP_CYC = `PDW_STARTUP_CYC,
  parameter SUSPEND_CYC = `PDW_SUSPEND_CYC
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        pd_enter,
  input  wire [7:0]  power_control_ext_reg,
  input  wire        wake_pin,
  input  wire        usb_activity,
  input  wire        usb_rx_enable,
  input  wire        xtal_stable,
  input  wire        wake_int_ack,
  input  wire        return_from_interrupt,
  input  wire        usb_clock_enable_bit,
  output wire        power_down,
  output reg         rc_osc_enable,
  output reg         wdog_start,
  output reg         wake_int_req,
  output reg  [15:0] wake_vector,
  output reg         resume_after_pd,
  output wire        periph_freeze,
  output wire        int_disable,
  output wire        usb_suspended
);
  // Phase codes of the wake-up walk.  RUN is normal execution and also the reset state, so a
  // device that never enables wake simply stays there until the next power-down request.
  // PD is power-down proper: the RC oscillator is off and only the selected wake source is
  // watched.  LATCH is the pin latch phase, STARTUP waits for the crystal and the start-up
  // delay, WAKEINT holds the wake interrupt request until the core takes it, and RESTORE
  // covers the time in which software brings the USB clocks back.  The codes are plain binary
  // because nothing outside this module decodes them.
  localparam ST_RUN     = 3'd0;
  localparam ST_PD      = 3'd1;
  localparam ST_LATCH   = 3'd2;
  localparam ST_STARTUP = 3'd3;
  localparam ST_WAKEINT = 3'd4;
  localparam ST_RESTORE = 3'd5;

  // The counter is shared by the latch and start-up phases; it is never needed by both at once,
  // and one wide counter costs less than two.  The configuration copy and the two restore flags
  // are the only other state the walk keeps.
  reg [2:0]            state_reg;
  reg [2:0]            state_next;
  reg [`PDW_CNT_W-1:0] cnt_reg;
  reg [7:0]            cfg_reg;
  reg                  isr_done_reg;
  reg                  clk_done_reg;
  wire                 usb_wake_trig;

  // Wake source decode is used in several places, so it lives in one function.  Only the
  // enable bit and the source bit are looked at; the remaining bits of the configuration byte
  // carry no meaning for the wake-up walk and are ignored rather than refused.
  function src_ok;
    input [7:0] cfg;
    input       want_usb;
    begin
      src_ok = cfg[`PDW_CFG_EN_BIT] && (cfg[`PDW_CFG_SRC_BIT] == want_usb);
    end
  endfunction

  // The suspend detector runs in every state, also outside power-down, so that a bus that went
  // quiet before power-down was requested is already suspended when the wake source is armed.
  // Its trigger is a single-cycle pulse and is only acted on while the walk sits in PD.
  pdw_usb_suspend #(
    .SUSPEND_CYC   (SUSPEND_CYC)
  ) u_susp (
    .clk           (clk),
    .rst_b         (rst_b),
    .usb_activity  (usb_activity),
    .usb_rx_enable (usb_rx_enable),
    .usb_suspended (usb_suspended),
    .usb_wake_trig (usb_wake_trig)
  );

  // Next state; a pin wake that rises before the latch time is dropped back to power-down.
  // The pin is looked at on every latch cycle, not only at its end, so a short glitch on the
  // pin cannot start the oscillator watchdog.  A USB trigger skips the latch phase, because the
  // suspend detector has already qualified the bus activity.  Requests that arrive in a state
  // that does not expect them are ignored rather than stored.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      // Power-down is taken only from normal run; a request in any other state is dropped.
      ST_RUN: begin
        if (pd_enter) begin
          state_next = ST_PD;
        end
      end
      ST_PD: begin
        if (src_ok(cfg_reg, 1'b0) && !wake_pin) begin
          state_next = ST_LATCH;
        end else if (src_ok(cfg_reg, 1'b1) && usb_wake_trig) begin
          state_next = ST_STARTUP;
        end
      end
      ST_LATCH: begin
        if (wake_pin) begin
          state_next = ST_PD;
        end else if (cnt_reg >= LATCH_CYC[`PDW_CNT_W-1:0] - 1'b1) begin
          state_next = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (xtal_stable && cnt_reg >= STARTUP_CYC[`PDW_CNT_W-1:0] - 1'b1) begin
          state_next = ST_WAKEINT;
        end
      end
      // The acknowledge is the core taking the vector; the request drops on the same edge.
      ST_WAKEINT: begin
        if (wake_int_ack) begin
          state_next = ST_RESTORE;
        end
      end
      // Both the return and the clock enable must have been seen before normal run resumes.
      ST_RESTORE: begin
        if (isr_done_reg && clk_done_reg) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // State, counter and handshake bookkeeping.  The counter restarts on every state change.
  // In start-up the counter also restarts whenever the crystal flag drops, so the delay is
  // always measured from the last moment the crystal became stable; a crystal that keeps
  // dropping out holds the device in start-up, which is the safe way to fail.  The counter
  // saturates instead of wrapping so that a very long stay in one state cannot fake an expiry.
  always @(posedge clk) begin
    // Reset returns to normal run with the RC oscillator on, as after any hard reset.
    if (!rst_b) begin
      state_reg       <= ST_RUN;
      cnt_reg         <= {`PDW_CNT_W{1'b0}};
      cfg_reg         <= 8'h00;
      isr_done_reg    <= 1'b0;
      clk_done_reg    <= 1'b0;
      rc_osc_enable   <= 1'b1;
      wdog_start      <= 1'b0;
      wake_int_req    <= 1'b0;
      wake_vector     <= 16'h0000;
      resume_after_pd <= 1'b0;
    end else begin
      state_reg       <= state_next;
      wdog_start      <= 1'b0;
      resume_after_pd <= 1'b0;
      if (state_next != state_reg) begin
        cnt_reg <= {`PDW_CNT_W{1'b0}};
      end else if (state_reg == ST_STARTUP && !xtal_stable) begin
        cnt_reg <= {`PDW_CNT_W{1'b0}};
      end else if (cnt_reg != {`PDW_CNT_W{1'b1}}) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      // Configuration is captured on entry so a late write cannot change the wake source.
      // Writes while powered down or waking take effect only at the next power-down entry.
      if (state_reg == ST_RUN && pd_enter) begin
        cfg_reg <= power_control_ext_reg;
      end
      // Oscillator stops in power-down and restarts on any wake.
      // It is registered so that the oscillator enable never glitches while the state decodes.
      rc_osc_enable <= (state_next != ST_PD);
      // The watchdog start is a one-cycle pulse on every entry into start-up.
      if (state_reg != ST_STARTUP && state_next == ST_STARTUP) begin
        wdog_start <= 1'b1;
      end
      // The wake request stands until the core acknowledges it; raising it wins over an
      // acknowledge in the same cycle.
      if (state_next == ST_WAKEINT && state_reg != ST_WAKEINT) begin
        wake_int_req <= 1'b1;
        wake_vector  <= `PDW_WAKE_VECTOR;
      end else if (wake_int_ack) begin
        wake_int_req <= 1'b0;
      end
      // Both restore flags are cleared while the wake request waits, so leftovers from an
      // earlier wake cannot end the restore phase early.  Either order of return and clock
      // enable is accepted, since the clock restore may also be done after the return.
      if (state_reg == ST_WAKEINT) begin
        isr_done_reg <= 1'b0;
        clk_done_reg <= 1'b0;
      end else if (state_reg == ST_RESTORE) begin
        if (return_from_interrupt && !isr_done_reg) begin
          isr_done_reg    <= 1'b1;
          resume_after_pd <= 1'b1;
        end
        if (usb_clock_enable_bit) begin
          clk_done_reg <= 1'b1;
        end
      end
    end
  end

  // The status outputs below are decoded straight from the state register, so they change
  // on the same edge as the state and need no extra flops.  The peripheral freeze and the
  // interrupt block differ only in power-down itself, where the core is stopped anyway.
  // Every interrupt stays blocked until the restore phase ends; the wake interrupt itself is
  // raised on its own request line and does not pass through this block.
  assign power_down    = (state_reg == ST_PD);
  // Peripherals stay frozen through restore; the CPU itself runs to do the restore.
  assign periph_freeze = (state_reg != ST_RUN);
  assign int_disable   = (state_reg == ST_LATCH) || (state_reg == ST_STARTUP) ||
                         (state_reg == ST_WAKEINT) || (state_reg == ST_RESTORE);
endmodule
`default_nettype wire

// [verif/pdw_seq_props.sv]
// Checker for the power-down wake-up sequencer ports.
`timescale 1ns/1ns
`default_nettype none
module pdw_seq_props #(parameter STARTUP_CYC = 10) (
  input wire logic       clk, rst_b, pd_enter, wake_pin, usb_rx_enable, xtal_stable,
  input wire logic       wake_int_ack, return_from_interrupt, power_down, rc_osc_enable,
  input wire logic       wdog_start, wake_int_req, resume_after_pd, periph_freeze, int_disable,
  input wire logic       usb_clock_enable_bit,
  input wire logic [7:0] power_control_ext_reg,
  input wire logic [15:0] wake_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  int xc = 0;
  // Length of the current run of stable crystal cycles.
  always @(posedge clk) xc <= xtal_stable ? xc + 1 : 0;
  chk_pd_entry: assert property (pd_enter && !periph_freeze
    |=> power_down && !rc_osc_enable) else $error("power-down not entered");
  chk_pin_wake: assert property (power_down && !wake_pin
    && power_control_ext_reg == 8'h80 |=> !power_down && int_disable)
    else $error("pin low did not wake");
  chk_no_wake: assert property (power_down && !power_control_ext_reg[7] |=> power_down)
    else $error("woke without enable");
  chk_usb_gate: assert property (power_down && !usb_rx_enable
    && power_control_ext_reg == 8'h90 |=> power_down) else $error("woke with receiver off");
  chk_wdog_pulse: assert property (wdog_start |-> int_disable ##1 !wdog_start)
    else $error("bad watchdog start pulse");
  chk_startup_wait: assert property ($rose(wake_int_req) |->
    xc >= STARTUP_CYC - 1 && wake_vector == 16'h007b) else $error("early wake interrupt");
  chk_req_hold: assert property (wake_int_req && !wake_int_ack |=> wake_int_req)
    else $error("wake request dropped");
  chk_freeze_span: assert property (int_disable |-> periph_freeze)
    else $error("peripherals ran early");
  chk_resume_cause: assert property (resume_after_pd |-> $past(return_from_interrupt))
    else $error("resume without return");
  chk_restore_end: assert property ($fell(periph_freeze) |->
    $past(usb_clock_enable_bit) && $past(int_disable)) else $error("restore ended early");
endmodule
bind pdw_sequencer pdw_seq_props #(.STARTUP_CYC(STARTUP_CYC)) u_props (.clk(clk), .rst_b(rst_b),
  .pd_enter(pd_enter), .wake_pin(wake_pin), .usb_rx_enable(usb_rx_enable),
  .xtal_stable(xtal_stable), .wake_int_ack(wake_int_ack),
  .return_from_interrupt(return_from_interrupt), .power_down(power_down),
  .rc_osc_enable(rc_osc_enable), .wdog_start(wdog_start), .wake_int_req(wake_int_req),
  .resume_after_pd(resume_after_pd), .periph_freeze(periph_freeze),
  .int_disable(int_disable), .power_control_ext_reg(power_control_ext_reg),
  .usb_clock_enable_bit(usb_clock_enable_bit),
  .wake_vector(wake_vector));
`default_nettype wire

// [verif/pdw_wake_src.sv]
// Far-side model: wake pin driver and USB bus activity source.
`timescale 1ns/1ns
`default_nettype none
module pdw_wake_src (
  input wire logic        clk, pin_go, usb_go,
  input wire logic [15:0] low_cyc,
  output var logic        wake_pin, usb_activity
);
  int n = 0;
  int u = 0;
  initial wake_pin = 1'b1;
  initial usb_activity = 1'b0;
  // The pin idles high so power-down is never left by accident; lows last as commanded.
  always @(posedge clk) begin
    if (pin_go) n = low_cyc; else if (n > 0) n--;
    if (usb_go) u = 3; else if (u > 0) u--;
    wake_pin <= (n == 0);
    usb_activity <= (u > 0);
  end
endmodule
`default_nettype wire

// [verif/pdw_sequencer_tb.sv]
// Self-checking testbench for the power-down wake-up sequencer.
`timescale 1ns/1ns
`default_nettype none
module pdw_sequencer_tb;
  localparam LC = 4;
  logic clk, rst_b, pd_enter, usb_rx_enable, xtal_stable, wake_int_ack, return_from_interrupt;
  logic usb_clock_enable_bit, pin_go, usb_go, b;
  logic [7:0] cfg;
  logic [15:0] low_cyc;
  wire wake_pin, usb_activity, power_down, rc_osc_enable, wdog_start, wake_int_req;
  wire resume_after_pd, periph_freeze, int_disable, usb_suspended;
  wire [15:0] wake_vector;
  int mismatches, n_compared, i, r0;
  int n_res = 0;
  pdw_sequencer #(.LATCH_CYC(LC), .STARTUP_CYC(10), .SUSPEND_CYC(20)) i_dut (.clk(clk),
    .rst_b(rst_b), .pd_enter(pd_enter), .power_control_ext_reg(cfg), .wake_pin(wake_pin),
    .usb_activity(usb_activity), .usb_rx_enable(usb_rx_enable), .xtal_stable(xtal_stable),
    .wake_int_ack(wake_int_ack), .return_from_interrupt(return_from_interrupt),
    .usb_clock_enable_bit(usb_clock_enable_bit), .power_down(power_down),
    .rc_osc_enable(rc_osc_enable), .wdog_start(wdog_start), .wake_int_req(wake_int_req),
    .wake_vector(wake_vector), .resume_after_pd(resume_after_pd),
    .periph_freeze(periph_freeze), .int_disable(int_disable), .usb_suspended(usb_suspended));
  pdw_wake_src i_src (.clk(clk), .pin_go(pin_go), .usb_go(usb_go), .low_cyc(low_cyc),
    .wake_pin(wake_pin), .usb_activity(usb_activity));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Resume is a one-cycle pulse, so it is counted rather than sampled.
  always @(posedge clk) if (resume_after_pd) n_res <= n_res + 1;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The latch phase starts one edge after the low is seen, so the pin must be low LC + 1 edges.
  function automatic bit exp_wake(input [7:0] c, input bit usb, input bit rx, input int low);
    return (c == 8'h80 && !usb && low > LC) || (c == 8'h90 && usb && rx);
  endfunction
  // One power-down with a chosen source; no-wake cases end with a reset, the only way out.
  task automatic wake(input [7:0] c, input bit usb, input bit rx, input int low);
    cfg = c;
    usb_rx_enable = rx;
    xtal_stable = 0;
    usb_clock_enable_bit = 0;
    pd_enter = 1;
    cyc(1);
    pd_enter = 0;
    cyc(1);
    chk("power_down", power_down, 1);
    chk("rc_osc_enable", rc_osc_enable, 0);
    for (i = 0; i < 40 && usb && rx && !usb_suspended; i++) cyc(1);
    if (usb && rx) chk("usb_suspended", usb_suspended, 1);
    low_cyc = low[15:0];
    pin_go = !usb;
    usb_go = usb;
    cyc(1);
    {pin_go, usb_go} = 2'b00;
    // The crystal flag drops once in mid start-up; the delay must start over.
    for (i = 0; i < 80 && !wake_int_req; i++) begin
      xtal_stable = (i != 9) && (xtal_stable || wdog_start || usb || i == 10);
      cyc(1);
    end
    chk("wake_int_req", wake_int_req, exp_wake(c, usb, rx, low));
    if (!exp_wake(c, usb, rx, low)) begin
      chk("power_down", power_down, 1);
      rst_b = 0;
      cyc(5);
      rst_b = 1;
      return;
    end
    chk("wake_vector", wake_vector, 16'h007b);
    chk("rc_osc_enable", rc_osc_enable, 1);
    if (usb) chk("usb_suspended", usb_suspended, 0);
    wake_int_ack = 1;
    cyc(1);
    wake_int_ack = 0;
    r0 = n_res;
    b = $urandom_range(1);
    // Clock restore before or after the routine returns, in random order.
    repeat (2) begin
      if (b) usb_clock_enable_bit = 1; else return_from_interrupt = 1;
      cyc(1);
      return_from_interrupt = 0;
      b = !b;
      cyc(2);
      chk("int_disable", int_disable, !usb_clock_enable_bit || n_res == r0);
      chk("periph_freeze", periph_freeze, !usb_clock_enable_bit || n_res == r0);
    end
    chk("periph_freeze", periph_freeze, 0);
    chk("resume", n_res - r0, 1);
  endtask
  initial begin
    {pd_enter, wake_int_ack, return_from_interrupt, usb_clock_enable_bit, pin_go, usb_go} = 0;
    {cfg, usb_rx_enable, xtal_stable, low_cyc, mismatches, n_compared} = 0;
    rst_b = 0;
    void'($urandom(32'h3d92901d));
    cyc(5);
    rst_b = 1;
    chk("wake_vector", wake_vector, 0);
    for (int k = 0; k < 3; k++) wake(8'h80, 0, 1, LC + 1 + $urandom_range(5));
    wake(8'h80, 0, 1, LC);
    wake(8'h80, 0, 1, LC - 2);
    wake(8'h00, 0, 1, 20);
    wake(8'h90, 0, 1, 20);
    wake(8'h90, 1, 1, 0);
    wake(8'h90, 1, 0, 0);
    wake(8'h80, 1, 1, 0);
    stop_test;
  end
  initial begin
    #1000000;
    mismatches++;
    stop_test;
  end
endmodule
`default_nettype wire
